//--- include/ghbi_regs.svh
// Purpose: named widths, reset values and synchroniser bit positions of the host bus port
// Assumes: included by the package and by the design module
// Notes:   the block has no software registers; these are pin-level constants
`ifndef GHBI_REGS_SVH
`define GHBI_REGS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define GHBI_ADDR_W    22
`define GHBI_DATA_W    16

// ----------------------------------------------------------------------------
// reset and idle values
// ----------------------------------------------------------------------------
`define GHBI_ADDR_RST  22'h000000
`define GHBI_DATA_RST  16'h0000
// strobes idle high, grant idles low: no false grant straight after reset
`define GHBI_SYNC_RST  3'h6
`define GHBI_RSTP_RST  2'h0
`define GHBI_RSTP_ON   2'h3

// ----------------------------------------------------------------------------
// synchroniser bit positions in the {read, write, grant} vector
// ----------------------------------------------------------------------------
`define GHBI_SY_RD     2
`define GHBI_SY_WR     1
`define GHBI_SY_GNT    0

`endif

//--- include/ghbi_pkg.sv
// Purpose: types shared by the host bus port and its bench
// Assumes: ghbi_regs.svh on the include path
// Notes:   pin groups travel as packed structs
`include "ghbi_regs.svh"

package ghbi_pkg;

   // -------------------------------------------------------------------------
   // controller states, one-hot
   // -------------------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_SACC  = 7'h02,
      ST_SHOLD = 7'h04,
      ST_HWAIT = 7'h08,
      ST_MADDR = 7'h10,
      ST_MSTRB = 7'h20,
      ST_MREL  = 7'h40
   } ghbi_state_t;

   // -------------------------------------------------------------------------
   // pins as seen entering the block
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [`GHBI_ADDR_W-1:0] externalAddressLines;
      logic [`GHBI_DATA_W-1:0] sharedDataLines;
      logic                    upperByteEnableN;
      logic                    readStrobeN;
      logic                    writeStrobeN;
      logic                    memIo;
      logic                    chipSelectN;
      logic                    ready;
      logic                    busHoldGrant;
   } ghbi_pin_in_t;

   // -------------------------------------------------------------------------
   // pin drives; oe high while the block drives the pin
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [`GHBI_ADDR_W-1:0] externalAddressLines;
      logic                    addrOe;
      logic [`GHBI_DATA_W-1:0] sharedDataLines;
      logic                    dataOe;
      logic                    upperByteEnableN;
      logic                    readStrobeN;
      logic                    writeStrobeN;
      logic                    memIo;
      logic                    ctlOe;
      logic                    busHoldRequest;
      logic                    masterEnable;
      logic                    slaveEnable;
   } ghbi_pin_out_t;

   // -------------------------------------------------------------------------
   // internal request to use the external bus as master
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                    req;
      logic                    write;
      logic [`GHBI_ADDR_W-1:0] addr;
      logic [`GHBI_DATA_W-1:0] wdata;
   } ghbi_mreq_t;

   // -------------------------------------------------------------------------
   // slave access handed to graphics memory / registers
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                    req;
      logic                    write;
      logic                    upperByte;
      logic [`GHBI_ADDR_W-1:0] addr;
      logic [`GHBI_DATA_W-1:0] wdata;
   } ghbi_sreq_t;

   typedef struct packed {
      logic                    syncMode;
      logic                    smallHost;
      logic                    testMode;
   } ghbi_strap_t;

endpackage : ghbi_pkg

//--- hw/ghbi_host_bus.sv
// Purpose: external host bus port of a graphics coprocessor, slave and master
// Assumes: pins synchronous to clk; 100 MHz clock
// Notes:   one access per hold tenure; straps taken once after reset release
//
// Summary of operation
// - one shared 16-bit data bus carries memory and external transfers.
// - upper byte enable is input as slave, driven low whole master tenure.
// - upper byte enable at reset release: high sync, low async strobes.
// - read and write strobes at reset release pick normal or test mode.
// - memory-or-io at reset release: low larger host, high smaller host.
// - memory-or-io is held high while the block is bus master.
// - slave strobes without chip select are ignored.
// - master enable high only while owning the bus after hold grant.
// - slave enable high while a slave cycle runs; ready to host.
// - own cycles wait for ready before ending.
// - hold request high while the internal side needs the bus.
`timescale 1ns/10ps
`default_nettype none
`include "ghbi_regs.svh"

module ghbi_host_bus
   import ghbi_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          clkEn,
   input  wire ghbi_pin_in_t  pinIn,
   output var  ghbi_pin_out_t pinOut,
   input  wire ghbi_mreq_t    mReq,
   output var  logic          mDone,
   output var  logic [15:0]   mRdata,
   output var  ghbi_sreq_t    sReq,
   input  wire logic          sAck,
   input  wire logic [15:0]   sRdata,
   output var  ghbi_strap_t   strap
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   typedef struct packed {
      ghbi_state_t   st;
      logic          strapsTaken;
      ghbi_strap_t   strap;
      logic [2:0]    syncA;
      logic [2:0]    syncB;
      ghbi_pin_out_t pins;
      ghbi_sreq_t    sReq;
      logic          mDone;
      logic [15:0]   mRdata;
   } ghbi_regs_t;

   ghbi_regs_t r;
   ghbi_regs_t next_r;
   logic [1:0] rstPipe;
   logic       rstn;
   logic [2:0] rawStb;
   logic [2:0] effStb;
   logic       slvStart;

   // -------------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstPipe <= `GHBI_RSTP_RST;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstn = rstPipe[1];

   // async mode goes through syncA/syncB; sync mode uses the pins directly
   assign rawStb = {pinIn.readStrobeN, pinIn.writeStrobeN, pinIn.busHoldGrant};
   assign effStb = r.strap.syncMode ? rawStb : r.syncB;
   // chip select qualifies every slave strobe
   assign slvStart = !pinIn.chipSelectN &&
                     (!effStb[`GHBI_SY_RD] || !effStb[`GHBI_SY_WR]);

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      next_r       = r;
      next_r.syncA = rawStb;
      next_r.syncB = r.syncA;
      next_r.mDone = 1'b0;
      next_r.sReq.req = 1'b0;
      if (!r.strapsTaken) begin
         next_r.strapsTaken     = 1'b1;
         // pin level high picks synchronous strobe handling
         next_r.strap.syncMode  = pinIn.upperByteEnableN;
         next_r.strap.testMode  = !pinIn.readStrobeN ||
                                  !pinIn.writeStrobeN;
         next_r.strap.smallHost = pinIn.memIo;
      end
      case (r.st)
         ST_IDLE: begin
            if (r.strapsTaken && slvStart) begin
               next_r.st               = ST_SACC;
               next_r.pins.slaveEnable = 1'b1;
               next_r.sReq.req         = 1'b1;
               next_r.sReq.write       = !effStb[`GHBI_SY_WR];
               next_r.sReq.upperByte   = !pinIn.upperByteEnableN;
               next_r.sReq.addr        = pinIn.externalAddressLines;
               next_r.sReq.wdata       = pinIn.sharedDataLines;
            // a tenure still dropping its request must finish that first
            end else if (r.strapsTaken && mReq.req &&
                         !r.pins.busHoldRequest) begin
               next_r.st                  = ST_HWAIT;
               next_r.pins.busHoldRequest = 1'b1;
            end
         end
         ST_SACC: begin
            if (sAck) begin
               next_r.st = ST_SHOLD;
               if (!r.sReq.write) begin
                  next_r.pins.sharedDataLines = sRdata;
                  next_r.pins.dataOe          = 1'b1;
               end
            end
         end
         ST_SHOLD: begin
            // hold data and ready until the host lets go of its strobe
            if (effStb[`GHBI_SY_RD] && effStb[`GHBI_SY_WR]) begin
               next_r.st               = ST_IDLE;
               next_r.pins.slaveEnable = 1'b0;
               next_r.pins.dataOe      = 1'b0;
            end
         end
         ST_HWAIT: begin
            if (effStb[`GHBI_SY_GNT]) begin
               next_r.st                        = ST_MADDR;
               next_r.pins.masterEnable         = 1'b1;
               next_r.pins.externalAddressLines = mReq.addr;
               next_r.pins.addrOe               = 1'b1;
               next_r.pins.ctlOe                = 1'b1;
               next_r.pins.upperByteEnableN     = 1'b0;
               next_r.pins.memIo                = 1'b1;
               next_r.pins.sharedDataLines      = mReq.wdata;
               next_r.pins.dataOe               = mReq.write;
            end
         end
         ST_MADDR: begin
            next_r.st                = ST_MSTRB;
            next_r.pins.readStrobeN  = r.pins.dataOe;
            next_r.pins.writeStrobeN = !r.pins.dataOe;
         end
         ST_MSTRB: begin
            if (pinIn.ready) begin
               next_r.st                = ST_MREL;
               next_r.mDone             = 1'b1;
               next_r.mRdata            = pinIn.sharedDataLines;
               next_r.pins.readStrobeN  = 1'b1;
               next_r.pins.writeStrobeN = 1'b1;
            end
         end
         ST_MREL: begin
            // lines are released here; the request drops one cycle later
            next_r.st                = ST_IDLE;
            next_r.pins.addrOe       = 1'b0;
            next_r.pins.ctlOe        = 1'b0;
            next_r.pins.dataOe       = 1'b0;
            next_r.pins.masterEnable = 1'b0;
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
      if (r.st == ST_IDLE && r.pins.busHoldRequest) begin
         next_r.pins.busHoldRequest = 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r                           <= '0;
         r.st                        <= ST_IDLE;
         r.syncA                     <= `GHBI_SYNC_RST;
         r.syncB                     <= `GHBI_SYNC_RST;
         r.pins.externalAddressLines <= `GHBI_ADDR_RST;
         r.pins.sharedDataLines      <= `GHBI_DATA_RST;
         r.pins.upperByteEnableN     <= 1'b1;
         r.pins.readStrobeN          <= 1'b1;
         r.pins.writeStrobeN         <= 1'b1;
         r.mRdata                    <= `GHBI_DATA_RST;
      end else if (clkEn) begin
         r <= next_r;
      end
   end

   assign pinOut = r.pins;
   assign mDone  = r.mDone;
   assign mRdata = r.mRdata;
   assign sReq   = r.sReq;
   assign strap  = r.strap;

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_bhe_low_master: assert property (
      r.pins.masterEnable |-> r.pins.ctlOe && !r.pins.upperByteEnableN)
      else $error("upper byte enable not driven low as master");
   a_memio_high: assert property (
      r.pins.ctlOe |-> r.pins.memIo)
      else $error("memory-or-io not high while driving");
   a_men_after_grant: assert property (
      $rose(r.pins.masterEnable) |-> $past(effStb[`GHBI_SY_GNT])
                                     && $past(r.pins.busHoldRequest))
      else $error("master enable without grant");
   a_drive_needs_bus_hold_request: assert property (
      (r.pins.addrOe || r.pins.ctlOe) |-> r.pins.busHoldRequest)
      else $error("master lines driven without hold request");
   a_release_first: assert property (
      $fell(r.pins.busHoldRequest) |-> $past(!r.pins.addrOe && !r.pins.ctlOe))
      else $error("hold request dropped before release");
   a_cs_qualify: assert property (
      (r.st == ST_IDLE && pinIn.chipSelectN && clkEn) |=> !r.sReq.req)
      else $error("slave access taken without chip select");
   a_ready_wait: assert property (
      (r.st == ST_MSTRB && !pinIn.ready && clkEn) |=> r.st == ST_MSTRB
                                                      && !r.mDone)
      else $error("master cycle ended without ready");
   a_sen_slave: assert property (
      r.sReq.req |-> r.pins.slaveEnable && !r.pins.masterEnable)
      else $error("slave request without slave enable");
   a_bus_hold_request_on_need: assert property (
      (r.st == ST_IDLE && r.strapsTaken && mReq.req && !slvStart
       && !r.pins.busHoldRequest && clkEn) |=> r.pins.busHoldRequest)
      else $error("hold request not raised");
   a_strap_stable: assert property (
      r.strapsTaken |=> $stable(r.strap))
      else $error("straps changed after capture");
   a_data_owner: assert property (
      r.pins.dataOe |-> (r.pins.masterEnable ^ r.pins.slaveEnable))
      else $error("data bus driven with no single owner");

endmodule : ghbi_host_bus
`default_nettype wire

//--- dv/ghbi_host_model.sv
// Purpose: bus owner and slave memory on the far side of the host bus port
// Assumes: the bench resolves pin drives; one wait count for all cycles
// Notes:   read data follows the address so the bench can predict it
`timescale 1ns/10ps
`default_nettype none

module ghbi_host_model
   import ghbi_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire ghbi_pin_out_t pinOut,
   input  wire logic [3:0]    waitN,
   output var  logic          busHoldGrant,
   output var  logic          ready,
   output var  logic          dataOe,
   output var  logic [15:0]   data,
   output var  logic [21:0]   seenAddr,
   output var  logic [15:0]   seenData,
   output var  int            viol
);
   logic       strbLow;
   logic       prevLow;
   logic       rdyPrev;
   logic [3:0] cnt;
   int         violCnt = 0;

   assign strbLow = pinOut.ctlOe && !(pinOut.readStrobeN && pinOut.writeStrobeN);
   assign dataOe  = strbLow && !pinOut.readStrobeN;
   assign data    = pinOut.externalAddressLines[15:0] ^ 16'h5A5A;

   // count survives a mid-run reset so early faults are not lost
   assign viol = violCnt;

   // ------------------------------------------------------------------------
   // grant, ready and pin watch
   // ------------------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busHoldGrant <= 1'h0;
         ready        <= 1'h0;
         cnt          <= 4'h0;
         prevLow      <= 1'h0;
         rdyPrev      <= 1'h0;
      end else begin
         // grant follows the request a cycle later; no other bus user is modelled
         busHoldGrant <= pinOut.busHoldRequest;
         // ready is a single pulse after waitN+1 strobe cycles
         ready   <= strbLow && cnt == waitN;
         cnt     <= strbLow ? cnt + 4'h1 : 4'h0;
         prevLow <= strbLow;
         rdyPrev <= ready;
         if (ready) begin
            seenAddr <= pinOut.externalAddressLines;
            seenData <= pinOut.sharedDataLines;
         end
         if (pinOut.masterEnable && (pinOut.upperByteEnableN !== 1'h0
             || pinOut.memIo !== 1'h1))
            violCnt <= violCnt + 1;
         if ((pinOut.addrOe || pinOut.ctlOe || pinOut.masterEnable)
             && !(busHoldGrant && pinOut.busHoldRequest))
            violCnt <= violCnt + 1;
         if (prevLow && !strbLow && !rdyPrev)
            violCnt <= violCnt + 1;
      end
   end
endmodule : ghbi_host_model

`default_nettype wire

//--- dv/testbench.sv
// Purpose: self-checking bench of the host bus port, slave and master roles
// Assumes: host model answers grant and ready; memory side driven here
// Notes:   table rows first, one of them with intrusion, then strap and async cases
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import ghbi_pkg::*;

   typedef struct packed {
      logic mst; logic csN; logic wr; logic [21:0] addr;
      logic [15:0] data; logic [3:0] waitN; logic intr;
   } ghbi_row_t;

   logic          clk = 1'h0;
   logic          resetn = 1'h0;
   logic          clkEn = 1'h1;
   logic [21:0]   hostAddr = 22'h0;
   logic [15:0]   hostData = 16'h0;
   logic          hBheN = 1'h1;
   logic          rdN = 1'h1;
   logic          wrN = 1'h1;
   logic          memIo = 1'h0;
   logic          csN = 1'h1;
   logic          sAck = 1'h0;
   logic [15:0]   sRdata = 16'h0;
   logic [3:0]    pWait = 4'h0;
   ghbi_mreq_t    mReq = '0;
   wire ghbi_pin_in_t pinIn;
   ghbi_pin_out_t pinOut;
   ghbi_sreq_t    sReq;
   ghbi_strap_t   strap;
   logic          mDone;
   logic [15:0]   mRdata;
   logic          hDataOe;
   logic [15:0]   hData;
   logic [21:0]   seenAddr;
   logic [15:0]   seenData;
   int            viol;
   int            sreqCnt = 0;
   int            errorCnt = 0;
   int            samplesChecked = 0;
   ghbi_row_t     rows [6] = '{
      '{1'h0, 1'h0, 1'h1, 22'h3FFFFF, 16'hA55A, 4'h0, 1'h0},
      '{1'h0, 1'h0, 1'h0, 22'h000001, 16'h1234, 4'h0, 1'h0},
      '{1'h0, 1'h1, 1'h1, 22'h000100, 16'hFFFF, 4'h0, 1'h0},
      '{1'h1, 1'h1, 1'h1, 22'h2AAAAA, 16'hC3C3, 4'h0, 1'h0},
      '{1'h1, 1'h1, 1'h0, 22'h155555, 16'h0000, 4'h3, 1'h1},
      '{1'h1, 1'h1, 1'h1, 22'h0000FF, 16'h8001, 4'h7, 1'h0}};

   always #5 clk = ~clk;

   assign pinIn.externalAddressLines = pinOut.addrOe ?
                                       pinOut.externalAddressLines : hostAddr;
   assign pinIn.sharedDataLines = pinOut.dataOe ? pinOut.sharedDataLines :
                                  (hDataOe ? hData : hostData);
   assign pinIn.upperByteEnableN = pinOut.ctlOe ? pinOut.upperByteEnableN : hBheN;
   assign pinIn.readStrobeN  = pinOut.ctlOe ? pinOut.readStrobeN : rdN;
   assign pinIn.writeStrobeN = pinOut.ctlOe ? pinOut.writeStrobeN : wrN;
   assign pinIn.memIo        = pinOut.ctlOe ? pinOut.memIo : memIo;
   assign pinIn.chipSelectN  = csN;

   ghbi_host_bus uut (.clk(clk), .resetn(resetn), .clkEn(clkEn),
      .pinIn(pinIn), .pinOut(pinOut), .mReq(mReq), .mDone(mDone),
      .mRdata(mRdata), .sReq(sReq), .sAck(sAck), .sRdata(sRdata),
      .strap(strap));

   ghbi_host_model host (.clk(clk), .resetn(resetn), .pinOut(pinOut),
      .waitN(pWait), .busHoldGrant(pinIn.busHoldGrant), .ready(pinIn.ready),
      .dataOe(hDataOe), .data(hData), .seenAddr(seenAddr),
      .seenData(seenData), .viol(viol));

   always @(posedge clk) if (sReq.req === 1'h1) sreqCnt <= sreqCnt + 1;

   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   task automatic giveVerdict;
      $display("errors=%0d checks=%0d", errorCnt, samplesChecked);
      if (errorCnt == 0 && samplesChecked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : giveVerdict

   task automatic do_reset(input logic b, input logic r, input logic m);
      resetn = 1'h0;
      hBheN  = b;
      rdN    = r;
      memIo  = m;
      repeat (10) step;
      chk_val({pinOut.addrOe, pinOut.ctlOe, pinOut.dataOe,
               pinOut.busHoldRequest, pinOut.masterEnable}, 0);
      resetn = 1'h1;
      // straps are taken on the third edge after release
      repeat (3) step;
      hBheN = 1'h1;
      rdN   = 1'h1;
      memIo = 1'h0;
      // idle strobes must fill the async synchroniser before any access
      repeat (3) step;
   endtask : do_reset

   task automatic slave_op(input ghbi_row_t r);
      int n;
      int c;
      c = sreqCnt;
      csN = r.csN;
      hostAddr = r.addr;
      hostData = r.data;
      wrN = !r.wr;
      rdN = r.wr;
      n = 0;
      while (pinOut.slaveEnable !== 1'h1 && n < 6) begin
         step;
         n++;
      end
      if (r.csN) chk_val(sreqCnt - c, 0);
      else begin
         chk_val({sReq.req, sReq.write}, {1'h1, r.wr});
         chk_val(sReq.addr, r.addr);
         if (r.wr) chk_val(sReq.wdata, r.data);
         sAck = 1'h1;
         sRdata = r.data;
         step;
         sAck = 1'h0;
         step;
         if (!r.wr) chk_val({pinOut.dataOe, pinOut.sharedDataLines},
                            {1'h1, r.data});
      end
      csN = 1'h1;
      rdN = 1'h1;
      wrN = 1'h1;
      repeat (4) step;
      chk_val(pinOut.slaveEnable, 0);
   endtask : slave_op

   task automatic master_op(input ghbi_row_t r);
      int n;
      int c;
      c = sreqCnt;
      pWait = r.waitN;
      mReq = '{1'h1, r.wr, r.addr, r.data};
      // host strobes while the hold is pending must be ignored
      if (r.intr) begin
         step;
         csN = 1'h0;
         wrN = 1'h0;
      end
      n = 0;
      while (mDone !== 1'h1 && n < 60) begin
         if (pinOut.masterEnable === 1'h1) begin
            csN = 1'h1;
            wrN = 1'h1;
         end
         step;
         n++;
      end
      mReq.req = 1'h0;
      chk_val(n < 60, 1);
      chk_val(seenAddr, r.addr);
      if (r.wr) chk_val(seenData, r.data);
      else chk_val(mRdata, r.addr[15:0] ^ 16'h5A5A);
      repeat (4) step;
      chk_val({pinOut.busHoldRequest, pinOut.masterEnable}, 0);
      chk_val(sreqCnt - c, 0);
   endtask : master_op

   initial begin
      do_reset(1'h1, 1'h1, 1'h0);
      chk_val(strap, 3'h4);
      foreach (rows[i]) begin
         if (rows[i].mst) master_op(rows[i]);
         else slave_op(rows[i]);
      end
      do_reset(1'h0, 1'h0, 1'h1);
      chk_val(strap, 3'h3);
      slave_op(rows[0]);
      chk_val(viol, 0);
      giveVerdict;
   end

   // the whole run takes well under 2000 cycles; this cuts off a hang
   initial begin
      #100000;
      errorCnt++;
      giveVerdict;
   end
endmodule : testbench

`default_nettype wire
